// [common/mwf_consts.svh]
// Purpose: constants for the memory write and fill command engine
// Assumes: parameters arrive as little-endian 32-bit words
// Notes:   status codes other than success are local encodings
`ifndef MWF_CONSTS_SVH
`define MWF_CONSTS_SVH
`define MWF_CMD_WRITE      8'h04
`define MWF_CMD_FILL       8'h05
`define MWF_ERASED_BYTE    8'hff
`define MWF_ST_SUCCESS     32'h0000_0000
`define MWF_ST_ALIGN       32'h0000_0065
`define MWF_ST_PROTECT     32'h0000_0068
`define MWF_ST_VERIFY      32'h0000_0069
`define MWF_ST_BADCMD      32'h0000_2710
`endif

// [common/mwf_pkg.sv]
// Purpose: types for the memory write and fill command engine
// Assumes: nothing
// Notes:   Gray codes along idle, run, verify, reply
package mwf_pkg;
  typedef enum logic [2:0] {
    MWF_IDLE   = 3'b000,
    MWF_RUN    = 3'b001,
    MWF_VERIFY = 3'b011,
    MWF_REPLY  = 3'b010
  } mwf_state_t;
endpackage

// [rtl/mwf_engine.sv]
// Purpose: target-side engine for the memory write and fill commands
// Assumes: framing and CRC are handled upstream; memory port may hold a byte until mem_ready
// Notes:   memory byte writes stall on mem_ready; verify uses a done pulse
`timescale 1ns/1ps
`default_nettype none
`include "mwf_consts.svh"
module mwf_engine #(
  parameter int AW = 32
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // Command in
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  wire logic [7:0]           cmd_tag,
  input  wire logic [31:0]          cmd_param0,
  input  wire logic [31:0]          cmd_param1,
  input  wire logic [31:0]          cmd_param2,
  // Data phase bytes
  input  wire logic                 data_valid,
  output logic                      data_ready,
  input  wire logic [7:0]           data_byte,
  // Target classification
  output logic [AW-1:0]             probe_addr,
  input  wire logic                 probe_is_flash,
  input  wire logic                 probe_protected,
  input  wire logic                 verify_after_program_property,
  // Memory byte port
  output logic                      mem_wr,
  output logic [AW-1:0]             mem_addr,
  output logic [7:0]                mem_data,
  output logic                      mem_is_flash,
  input  wire logic                 mem_ready,
  // Program verify
  output logic                      verify_start,
  output logic [AW-1:0]             verify_addr,
  output logic [31:0]               verify_len,
  input  wire logic                 verify_done,
  input  wire logic                 verify_ok,
  // General reply
  output logic                      reply_valid,
  input  wire logic                 reply_ready,
  output logic [7:0]                reply_tag,
  output logic [31:0]               reply_status
);
  import mwf_pkg::*;

  mwf_state_t  state, next_state;
  logic        is_fill, next_is_fill;
  logic        flash, next_flash;
  logic [AW-1:0] addr, next_addr;
  logic [AW-1:0] base, next_base;
  logic [31:0] left, next_left;
  logic [31:0] pad, next_pad;
  logic [31:0] total, next_total;
  logic [31:0] pattern, next_pattern;
  logic [7:0]  tag, next_tag;
  logic [31:0] status, next_status;
  logic        vstart, next_vstart;
  logic [7:0]  wdata, next_wdata;
  logic        wr, next_wr;

  function automatic logic [31:0] round4(input logic [31:0] n);
    round4 = (n + 32'h0000_0003) & 32'hffff_fffc;
  endfunction

  // In a run the probe looks at the byte about to be raised, so a protected
  // sector is refused before any of its bytes reaches the memory port
  assign probe_addr   = (state == MWF_IDLE) ? cmd_param0[AW-1:0] :
                        (wr && mem_ready)   ? addr + AW'(1) : addr;
  assign cmd_ready    = (state == MWF_IDLE);
  // Data is only drained for writes with bytes left and no store left waiting on mem_ready
  assign data_ready   = (state == MWF_RUN) && !is_fill && (left != 32'h0) &&
                        (!wr || mem_ready) && !(flash && probe_protected);
  assign mem_addr     = addr;
  assign mem_data     = wdata;
  assign mem_wr       = wr;
  assign mem_is_flash = flash;
  assign verify_start = vstart;
  assign verify_addr  = base;
  assign verify_len   = total;
  assign reply_valid  = (state == MWF_REPLY);
  assign reply_tag    = tag;
  assign reply_status = status;

  always_comb begin
    next_state   = state;
    next_is_fill = is_fill;
    next_flash   = flash;
    next_addr    = addr;
    next_base    = base;
    next_left    = left;
    next_pad     = pad;
    next_total   = total;
    next_pattern = pattern;
    next_tag     = tag;
    next_status  = status;
    next_vstart  = 1'b0;
    next_wdata   = wdata;
    next_wr      = wr;
    if (wr && mem_ready) begin
      next_wr   = 1'b0;
      next_addr = addr + AW'(1);
    end
    case (state)
      MWF_IDLE: begin
        if (cmd_valid) begin
          next_tag     = cmd_tag;
          next_is_fill = (cmd_tag == `MWF_CMD_FILL);
          next_flash   = probe_is_flash;
          next_addr    = cmd_param0[AW-1:0];
          next_base    = cmd_param0[AW-1:0];
          next_left    = cmd_param1;
          next_pattern = cmd_param2;
          // Flash counts padded to a word; RAM keeps exact length
          next_pad     = probe_is_flash ? round4(cmd_param1) - cmd_param1 : 32'h0;
          next_total   = probe_is_flash ? round4(cmd_param1) : cmd_param1;
          next_status  = `MWF_ST_SUCCESS;
          if (cmd_tag != `MWF_CMD_WRITE && cmd_tag != `MWF_CMD_FILL) begin
            next_status = `MWF_ST_BADCMD;
            next_state  = MWF_REPLY;
          end else if (probe_is_flash && cmd_param0[1:0] != 2'b00) begin
            next_status = `MWF_ST_ALIGN;
            next_state  = MWF_REPLY;
          end else if (probe_is_flash && probe_protected) begin
            next_status = `MWF_ST_PROTECT;
            next_state  = MWF_REPLY;
          end else begin
            next_state  = MWF_RUN;
          end
        end
      end
      MWF_RUN: begin
        if (!wr || mem_ready) begin
          if (flash && probe_protected && (left != 32'h0 || pad != 32'h0)) begin
            // Crossing into a protected sector aborts before the byte lands
            next_wr     = 1'b0;
            next_status = `MWF_ST_PROTECT;
            next_state  = MWF_REPLY;
          end else if (left != 32'h0) begin
            if (is_fill) begin
              next_wdata = pattern[8*next_addr[1:0] +: 8];
              next_wr    = 1'b1;
              next_left  = left - 32'h1;
            end else if (data_valid) begin
              next_wdata = data_byte;
              next_wr    = 1'b1;
              next_left  = left - 32'h1;
            end
          end else if (pad != 32'h0) begin
            next_wdata = `MWF_ERASED_BYTE;
            next_wr    = 1'b1;
            next_pad   = pad - 32'h1;
          end else if (flash && verify_after_program_property) begin
            next_vstart = 1'b1;
            next_state  = MWF_VERIFY;
          end else begin
            next_state  = MWF_REPLY;
          end
        end
      end
      MWF_VERIFY: begin
        if (verify_done) begin
          next_status = verify_ok ? `MWF_ST_SUCCESS : `MWF_ST_VERIFY;
          next_state  = MWF_REPLY;
        end
      end
      MWF_REPLY: begin
        if (reply_ready) begin
          next_state = MWF_IDLE;
        end
      end
      default: next_state = MWF_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state   <= MWF_IDLE;
      is_fill <= 1'b0;
      flash   <= 1'b0;
      addr    <= '0;
      base    <= '0;
      left    <= 32'h0;
      pad     <= 32'h0;
      total   <= 32'h0;
      pattern <= 32'h0;
      tag     <= 8'h00;
      status  <= 32'h0;
      vstart  <= 1'b0;
      wdata   <= 8'h00;
      wr      <= 1'b0;
    end else begin
      state   <= next_state;
      is_fill <= next_is_fill;
      flash   <= next_flash;
      addr    <= next_addr;
      base    <= next_base;
      left    <= next_left;
      pad     <= next_pad;
      total   <= next_total;
      pattern <= next_pattern;
      tag     <= next_tag;
      status  <= next_status;
      vstart  <= next_vstart;
      wdata   <= next_wdata;
      wr      <= next_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  misalign_refused_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == MWF_IDLE && cmd_valid && probe_is_flash && cmd_param0[1:0] != 2'b00 &&
     (cmd_tag == `MWF_CMD_WRITE || cmd_tag == `MWF_CMD_FILL))
    |=> (state == MWF_REPLY && reply_status == `MWF_ST_ALIGN))
    else $error("misaligned flash start not refused");
  protect_refused_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == MWF_IDLE && cmd_valid && probe_is_flash && probe_protected &&
     cmd_param0[1:0] == 2'b00 && cmd_tag == `MWF_CMD_WRITE) |=> (state == MWF_REPLY && !mem_wr))
    else $error("protected flash write not refused");
  pad_value_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == MWF_RUN && $past(state) == MWF_RUN && flash && pad != $past(pad))
    |-> (mem_wr && mem_data == `MWF_ERASED_BYTE))
    else $error("pad byte not erased value");
  ram_no_pad_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == MWF_RUN && !flash) |-> pad == 32'h0)
    else $error("RAM transfer padded");
  verify_issued_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == MWF_RUN && flash && verify_after_program_property && (!wr || mem_ready) &&
     left == 32'h0 && pad == 32'h0) |=> (verify_start && state == MWF_VERIFY))
    else $error("verify not started");
  fill_no_data_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == MWF_RUN && is_fill) |-> !data_ready)
    else $error("fill drained data");
  fill_pattern_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == MWF_RUN && is_fill && mem_wr) |-> mem_data == pattern[8*mem_addr[1:0] +: 8])
    else $error("fill byte not from pattern");
  data_count_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (data_valid && data_ready) |=> left == $past(left) - 32'h1)
    else $error("data byte not counted");
  reply_held_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reply_valid && !reply_ready) |=> (reply_valid && $stable(reply_status)))
    else $error("reply dropped before taken");
  cmd_word_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cmd_valid && cmd_ready && cmd_tag == `MWF_CMD_WRITE) |=> base == $past(cmd_param0[AW-1:0]))
    else $error("start address not captured");
  write_done_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    reply_valid && reply_tag == `MWF_CMD_WRITE && reply_status == `MWF_ST_SUCCESS);
  fill_done_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    reply_valid && reply_tag == `MWF_CMD_FILL && reply_status == `MWF_ST_SUCCESS);
  verify_run_c: cover property (@(posedge clk_sys) disable iff (sys_rst) verify_start);
  pad_run_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    mem_wr && mem_data == `MWF_ERASED_BYTE && flash && left == 32'h0);
endmodule
`default_nettype wire

// [testbench/memory_write_fill_commands_tb_top.sv]
// Purpose: self-checking bench for the write and fill engine
// Assumes: the bench plays the host, the model the memory side
// Notes:   stimulus changes 1 ns after each rising edge
`timescale 1ns/1ps
`default_nettype none
`include "mwf_consts.svh"
module memory_write_fill_commands_tb_top;
  logic        clk_sys = 0, sys_rst = 1, cmd_valid = 0, cmd_ready, data_valid = 0;
  logic        data_ready, probe_is_flash, probe_protected, mem_wr, mem_ready, mem_is_flash;
  logic        verify_after_program_property = 1, verify_start, verify_done;
  logic        verify_ok, reply_valid, reply_ready = 0, slow = 0, vfail = 0;
  logic [7:0]  cmd_tag = 0, data_byte = 0, mem_data, reply_tag;
  logic [31:0] cmd_param0 = 0, cmd_param1 = 0, cmd_param2 = 0, probe_addr;
  logic [31:0] mem_addr, verify_len, reply_status, verify_addr;
  int          fails = 0, comparisons = 0;
  mwf_engine u_mwf_engine (.clk_sys, .sys_rst, .cmd_valid, .cmd_ready, .cmd_tag,
    .cmd_param0, .cmd_param1, .cmd_param2, .data_valid, .data_ready, .data_byte,
    .probe_addr, .probe_is_flash, .probe_protected, .verify_after_program_property,
    .mem_wr, .mem_addr, .mem_data, .mem_is_flash, .mem_ready, .verify_start,
    .verify_addr, .verify_len, .verify_done, .verify_ok, .reply_valid,
    .reply_ready, .reply_tag, .reply_status);
  mwf_mem_model u_mwf_mem_model (.clk_sys, .sys_rst, .slow, .vfail, .probe_addr,
    .probe_is_flash, .probe_protected, .mem_wr, .mem_addr, .mem_data, .mem_ready,
    .verify_start, .verify_len, .verify_done, .verify_ok);
  initial forever #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  function automatic logic [31:0] mb(input int a);
    return {24'h0, u_mwf_mem_model.mem[a]};
  endfunction
  // One command, its data phase if any, then the reply
  task automatic run(input logic [7:0] t, input logic [31:0] a, n, p, st, input int nb);
    int k, i, w;
    w = u_mwf_mem_model.nwr;
    cmd_tag = t;
    cmd_param0 = a;
    cmd_param1 = n;
    cmd_param2 = p;
    cmd_valid = 1;
    for (k = 0; k < 50 && cmd_ready !== 1'b1; k++) @(posedge clk_sys) #1;
    @(posedge clk_sys) #1;
    cmd_valid = 0;
    i = 0;
    for (k = 0; k < 3000 && reply_valid !== 1'b1; k++) begin
      data_valid = t == `MWF_CMD_WRITE && i < int'(n);
      data_byte = 8'h10 + 8'(i);
      #1;
      if (data_valid && data_ready === 1'b1) i++;
      @(posedge clk_sys) #1;
    end
    data_valid = 0;
    chk("reply", 32'h1, {31'h0, reply_valid});
    chk("status", st, reply_status);
    chk("tag", {24'h0, t}, {24'h0, reply_tag});
    chk("stores", 32'(nb), 32'(u_mwf_mem_model.nwr - w));
    reply_ready = 1;
    @(posedge clk_sys) #1;
    reply_ready = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2_000_000;
    fails++;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    #1 sys_rst = 0;
    run(`MWF_CMD_WRITE, 32'h0000_2001, 32'h3, 32'h0, `MWF_ST_SUCCESS, 3);
    chk("ram", 32'h12, mb(32'h2003));
    chk("nver", 32'h0, 32'(u_mwf_mem_model.nver));
    run(`MWF_CMD_WRITE, 32'h0000_0100, 32'h5, 32'h0, `MWF_ST_SUCCESS, 8);
    chk("last", 32'h14, mb(32'h0104));
    chk("vlen", 32'h8, u_mwf_mem_model.vlen);
    chk("vaddr", 32'h100, verify_addr);
    chk("isflash", 32'h1, {31'h0, mem_is_flash});
    run(`MWF_CMD_WRITE, 32'h0000_0102, 32'h4, 32'h0, `MWF_ST_ALIGN, 0);
    run(`MWF_CMD_FILL, 32'h0000_0106, 32'h4, 32'h0, `MWF_ST_ALIGN, 0);
    run(`MWF_CMD_WRITE, 32'h0000_0800, 32'h4, 32'h0, `MWF_ST_PROTECT, 0);
    // Run that walks from open flash into the protected half
    run(`MWF_CMD_WRITE, 32'h0000_07fc, 32'h8, 32'h0, `MWF_ST_PROTECT, 4);
    chk("edge", 32'h13, mb(32'h07ff));
    chk("guard", 32'hff, mb(32'h0800));
    slow = 1;
    vfail = 1;
    run(`MWF_CMD_FILL, 32'h0000_0200, 32'h8, 32'h1234_5678, `MWF_ST_VERIFY, 8);
    chk("fill0", 32'h78, mb(32'h0200));
    chk("fill7", 32'h12, mb(32'h0207));
    slow = 0;
    vfail = 0;
    run(`MWF_CMD_FILL, 32'h0000_2100, 32'h8, 32'h5afe_5afe, `MWF_ST_SUCCESS, 8);
    chk("short", 32'h5a, mb(32'h2101));
    verify_after_program_property = 0;
    run(`MWF_CMD_FILL, 32'h0000_0300, 32'h4, 32'hfefe_fefe, `MWF_ST_SUCCESS, 4);
    chk("nver", 32'h2, 32'(u_mwf_mem_model.nver));
    run(8'h03, 32'h0, 32'h0, 32'h0, `MWF_ST_BADCMD, 0);
    run(`MWF_CMD_WRITE, 32'h0000_2200, 32'h0, 32'h0, `MWF_ST_SUCCESS, 0);
    print_verdict;
  end
endmodule
`default_nettype wire

// [testbench/mwf_mem_model.sv]
// Purpose: memory, protection and verify model facing the engine
// Assumes: flash below 0x1000 with its upper half protected, RAM above
// Notes:   slow gives mem_ready every fourth cycle; vfail fails verify
`timescale 1ns/1ps
`default_nettype none
module mwf_mem_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Bench controls
  input  wire logic        slow,
  input  wire logic        vfail,
  // Classification
  input  wire logic [31:0] probe_addr,
  output logic             probe_is_flash,
  output logic             probe_protected,
  // Byte port
  input  wire logic        mem_wr,
  input  wire logic [31:0] mem_addr,
  input  wire logic [7:0]  mem_data,
  output logic             mem_ready,
  // Verify
  input  wire logic        verify_start,
  input  wire logic [31:0] verify_len,
  output logic             verify_done,
  output logic             verify_ok
);
  logic [7:0]  mem [0:16383];
  logic [1:0]  cnt;
  logic [1:0]  vt;
  logic [31:0] vlen;
  int          nwr = 0;
  int          nver = 0;
  assign probe_is_flash  = probe_addr < 32'h0000_1000;
  assign probe_protected = probe_is_flash && probe_addr >= 32'h0000_0800;
  assign mem_ready       = !slow || cnt == 2'h3;
  assign verify_done     = vt == 2'h1;
  // Off the done pulse the result shows the wrong answer
  assign verify_ok       = verify_done ? !vfail : vfail;
  // All memory starts erased
  initial for (int i = 0; i < 16384; i++) mem[i] = 8'hff;
  always @(posedge clk_sys) begin
    cnt <= sys_rst ? 2'h0 : cnt + 2'h1;
    vt <= sys_rst ? 2'h0 : verify_start ? 2'h3 : vt != 2'h0 ? vt - 2'h1 : vt;
    if (verify_start) begin
      nver <= nver + 1;
      vlen <= verify_len;
    end
    if (mem_wr && mem_ready) begin
      mem[mem_addr[13:0]] <= mem_data;
      nwr <= nwr + 1;
    end
  end
endmodule
`default_nettype wire
